// File: inc/mbseq_pkg.sv
// Constants, register map and state encoding of the motor brake sequencer.
// Assumes a 250 MHz control clock and AXI4-Lite register access.
//
// Behaviour
// [R1] Sequencing on suppresses start DC braking, dwell
// [R2] Run from stop ramps to directional release frequency
// [R3] Release output waits for release current level
// [R4] Hold frequency for release hold time
// [R5] Stop command while running starts deceleration
// [R6] At engage frequency halt decel, engage brake
// [R7] Hold engage hold time, then zero frequency
// [R8] DC brake after hold when configured, then block
// [R9] Function code 35 routes brake signal to terminal
// [R10] Brake engaged after reset, released only between events
// [R11] Hold delays counted in ticks; zero means none
package mbseq_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00; // Sequencing enable
  localparam logic [5:0] OFS_REL_FWD = 6'h04; // Release freq forward, 0.01 Hz
  localparam logic [5:0] OFS_REL_REV = 6'h08; // Release freq reverse, 0.01 Hz
  localparam logic [5:0] OFS_REL_CUR = 6'h0c; // Release current level, 0.1 %
  localparam logic [5:0] OFS_REL_HOLD = 6'h10; // Release hold time, 0.01 s
  localparam logic [5:0] OFS_ENG_FREQ = 6'h14; // Engage frequency, 0.01 Hz
  localparam logic [5:0] OFS_ENG_HOLD = 6'h18; // Engage hold time, 0.01 s
  localparam logic [5:0] OFS_DCB_TIME = 6'h1c; // Post-stop DC braking time, 0.01 s
  localparam logic [5:0] OFS_DCB_LEVEL = 6'h20; // DC braking strength, 0.1 %
  localparam logic [5:0] OFS_RELAY_SEL = 6'h24; // Terminal function selectors
  localparam logic [5:0] OFS_STATUS = 6'h28; // Read-only state
  localparam int NUM_CFG = 10; // Writable registers at the low offsets

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int SEL_R1_LSB = 0; // Relay 1 function, 8 bits
  localparam int SEL_R2_LSB = 8; // Relay 2 function, 8 bits
  localparam int ST_STATE_LSB = 0; // State, 4 bits
  localparam int ST_BRAKE_BIT = 4; // Brake released
  localparam int ST_BLOCK_BIT = 5; // Output blocked
  localparam int ST_FREQ_LSB = 16; // Measured frequency, 16 bits

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_REL_FREQ = 32'h0000_0064; // 1.00 Hz
  localparam logic [31:0] RST_REL_CUR = 32'h0000_01f4; // 50.0 %
  localparam logic [31:0] RST_REL_HOLD = 32'h0000_0064; // 1.00 s
  localparam logic [31:0] RST_ENG_FREQ = 32'h0000_00c8; // 2.00 Hz
  localparam logic [31:0] RST_ENG_HOLD = 32'h0000_0064; // 1.00 s
  localparam logic [31:0] RST_DCB = 32'h0000_0000;
  localparam logic [31:0] RST_RELAY_SEL = 32'h0000_0023; // Relay 1 = brake
  localparam logic [7:0] BRAKE_FUNC_CODE = 8'h23; // Code 35

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000; // 250 MHz
  localparam int HOLD_UNIT_MS = 10; // Hold settings in 0.01 s steps
  // Divide before the last multiply so the 32-bit int never overflows
  localparam int HOLD_TICK_CYCLES = HOLD_UNIT_MS * 1000000 / CLK_PERIOD_PS * 1000; // 2,500,000

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_STOP, S_TO_REL, S_WAIT_CUR, S_REL_HOLD, S_RUN, S_DECEL, S_ENG_HOLD, S_DCB
  } mbseq_state_t;

endpackage

// File: verif/mbseq_load_model.sv
// Load model: shaft speed slews toward the reference, current is set by the bench.
// Assumes the sequencer clock and reset; all outputs are registered.
`timescale 1ns/10ps
module mbseq_load_model #(
  parameter logic [15:0] STEP = 16'h0010 // Slew per cycle, 0.01 Hz
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] freq_ref,
  input wire logic output_block,
  input wire logic [10:0] load_current,
  output logic [15:0] meas_freq,
  output logic [10:0] motor_current
);
  // ---------------------------------------------------------------
  // Shaft speed and current
  // ---------------------------------------------------------------
  // Blocked output drops speed at once; a real shaft coasts, but the bench stays short
  always_ff @(posedge aclk) begin
    if (!aresetn || output_block) begin
      meas_freq <= 16'h0000;
      motor_current <= 11'h000;
    end else begin
      motor_current <= load_current; // Weak current holds off the release
      if (meas_freq + STEP <= freq_ref) begin
        meas_freq <= meas_freq + STEP;
      end else if (meas_freq >= freq_ref + STEP) begin
        meas_freq <= meas_freq - STEP;
      end else begin
        meas_freq <= freq_ref;
      end
    end
  end
endmodule

// File: verif/testbench.sv
// Self-checking bench of the brake sequencer: registers, release and engage runs.
// Assumes the package is compiled first; a short hold tick keeps the run brief.
`timescale 1ns/10ps
module testbench;
  import mbseq_pkg::*;
  localparam int TICKS = 4; // Cycles per hold unit
  localparam logic [5:0] OFS_TAB [10] = '{OFS_CTRL, OFS_REL_FWD, OFS_REL_REV, OFS_REL_CUR, OFS_REL_HOLD,
    OFS_ENG_FREQ, OFS_ENG_HOLD, OFS_DCB_TIME, OFS_DCB_LEVEL, OFS_RELAY_SEL};
  localparam logic [31:0] RST_TAB [10] = '{RST_CTRL, RST_REL_FREQ, RST_REL_FREQ, RST_REL_CUR, RST_REL_HOLD,
    RST_ENG_FREQ, RST_ENG_HOLD, RST_DCB, RST_DCB, RST_RELAY_SEL};
  logic aclk, aresetn;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic run_cmd_pin, reverse_pin, freq_hold, dc_brake_on, output_block;
  logic start_dcb_dwell_inhibit, brake_release, relay1, relay2;
  logic [15:0] cmd_freq, meas_freq, freq_ref;
  logic [10:0] motor_current, load_current;
  int failures, total_checks;

  mbseq_top #(.TICK_CYCLES(TICKS)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .run_cmd_pin, .reverse_pin, .cmd_freq, .meas_freq, .motor_current, .freq_ref, .freq_hold, .dc_brake_on,
    .output_block, .start_dcb_dwell_inhibit, .brake_release, .relay1, .relay2);
  mbseq_load_model i_load (.aclk, .aresetn, .freq_ref, .output_block, .load_current, .meas_freq,
    .motor_current);

  // Free-running 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    chk(32'(s_axi_bvalid), 32'h1, "write answer");
    chk(32'(s_axi_bresp), 32'(er), "write response");
  endtask

  // Read and compare data and response
  task automatic rdc(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    chk(32'(s_axi_rvalid), 32'h1, "read answer");
    chk(s_axi_rdata, ed, "read data");
    chk(32'(s_axi_rresp), 32'(er), "read response");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    chk(32'({brake_release, output_block, relay1}), 32'h2, "reset outputs");
    for (int i = 0; i < 10; i++) rdc(OFS_TAB[i], RST_TAB[i], 2'b00);
    wr(OFS_STATUS, 32'h0000_00ff, 2'b10);
    rdc(6'h2c, 32'h0, 2'b10);
    wr(OFS_ENG_FREQ, 32'h0000_0123, 2'b00);
    rdc(OFS_ENG_FREQ, 32'h0000_0123, 2'b00);
    $display("test regs done");
  endtask

  task automatic t_fwd();
    int n;
    wr(OFS_REL_FWD, 32'd150, 2'b00);
    wr(OFS_REL_REV, 32'd120, 2'b00);
    wr(OFS_REL_CUR, 32'd300, 2'b00);
    wr(OFS_REL_HOLD, 32'd3, 2'b00);
    wr(OFS_ENG_FREQ, 32'd200, 2'b00);
    wr(OFS_ENG_HOLD, 32'd2, 2'b00);
    wr(OFS_CTRL, 32'h1, 2'b00);
    repeat (2) @(posedge aclk);
    chk(32'(start_dcb_dwell_inhibit), 32'h1, "inhibit on");
    load_current <= 11'd100;
    run_cmd_pin <= 1'b1;
    for (n = 0; n < 50 && freq_ref !== 16'd150; n++) @(posedge aclk);
    chk(32'(freq_ref), 32'd150, "forward release freq");
    for (n = 0; n < 200 && !(meas_freq >= 16'd150 && freq_hold); n++) @(posedge aclk);
    repeat (20) @(posedge aclk);
    chk(32'({brake_release, freq_hold}), 32'h1, "release waits current");
    load_current <= 11'd400;
    for (n = 0; n < 50 && brake_release !== 1'b1; n++) @(posedge aclk);
    chk(32'({brake_release, relay1}), 32'h3, "released on current");
    for (n = 0; n < 100 && freq_hold === 1'b1 && freq_ref === 16'd150; n++) @(posedge aclk);
    chk(32'(n >= 3 * TICKS && n <= 3 * TICKS + 2), 32'h1, "release hold length");
    for (n = 0; n < 5 && freq_ref !== 16'd1000; n++) @(posedge aclk);
    chk(32'(freq_ref), 32'd1000, "accelerate after hold");
    $display("test forward release done");
  endtask

  task automatic t_stop();
    int n;
    for (n = 0; n < 200 && meas_freq !== 16'd1000; n++) @(posedge aclk);
    run_cmd_pin <= 1'b0;
    for (n = 0; n < 10 && freq_ref !== 16'd200; n++) @(posedge aclk);
    chk(32'({freq_ref, brake_release}), 32'({16'd200, 1'b1}), "decel, brake still open");
    for (n = 0; n < 200 && brake_release !== 1'b0; n++) @(posedge aclk);
    chk(32'(meas_freq <= 16'd200 && freq_ref == 16'd200), 32'h1, "engage at freq");
    for (n = 0; n < 100 && freq_ref === 16'd200 && output_block === 1'b0; n++) @(posedge aclk);
    chk(32'(n >= 2 * TICKS && n <= 2 * TICKS + 2), 32'h1, "engage hold length");
    chk(32'({freq_ref, output_block, brake_release}), 32'h2, "stopped and blocked");
    $display("test stop done");
  endtask

  task automatic t_rev_dcb();
    int n;
    wr(OFS_REL_HOLD, 32'd0, 2'b00);
    wr(OFS_ENG_HOLD, 32'd0, 2'b00);
    wr(OFS_DCB_TIME, 32'd2, 2'b00);
    wr(OFS_DCB_LEVEL, 32'd5, 2'b00);
    wr(OFS_RELAY_SEL, 32'h0000_2300, 2'b00);
    reverse_pin <= 1'b1;
    run_cmd_pin <= 1'b1;
    for (n = 0; n < 50 && freq_ref !== 16'd120; n++) @(posedge aclk);
    chk(32'(freq_ref), 32'd120, "reverse release freq");
    for (n = 0; n < 200 && brake_release !== 1'b1; n++) @(posedge aclk);
    chk(32'({relay2, relay1}), 32'h2, "relay 2 routed");
    for (n = 0; n < 100 && freq_hold === 1'b1; n++) @(posedge aclk);
    chk(32'(n <= 2), 32'h1, "zero release hold");
    repeat (100) @(posedge aclk);
    run_cmd_pin <= 1'b0;
    for (n = 0; n < 300 && dc_brake_on !== 1'b1; n++) @(posedge aclk);
    chk(32'({freq_ref, output_block, brake_release}), 32'h0, "dc brake before block");
    for (n = 0; n < 100 && dc_brake_on === 1'b1 && output_block === 1'b0; n++) @(posedge aclk);
    chk(32'(n >= 2 * TICKS - 1 && n <= 2 * TICKS + 1), 32'h1, "dc brake length");
    chk(32'({output_block, dc_brake_on}), 32'h2, "blocked after dc brake");
    wr(OFS_CTRL, 32'h0, 2'b00);
    repeat (2) @(posedge aclk);
    chk(32'(start_dcb_dwell_inhibit), 32'h0, "inhibit off");
    $display("test reverse dc brake done");
  endtask

  // ---------------------------------------------------------------
  // Verdict and main sequence
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #80000;
    failures++;
    results();
  end

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1; // Always ready for answers
    s_axi_rready = 1'b1;
    run_cmd_pin = 1'b0;
    reverse_pin = 1'b0;
    cmd_freq = 16'd1000;
    load_current = 11'd0;
    failures = 0;
    total_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_fwd();
    t_stop();
    t_rev_dcb();
    results();
  end
endmodule

// File: verilog/mbseq_top.sv
// Brake sequencer of a motor drive with an AXI4-Lite register slave.
// Assumes run and direction arrive from pins; frequency and current
// measurements come from logic on the same clock.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module mbseq_top #(
  parameter int TICK_CYCLES = mbseq_pkg::HOLD_TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic run_cmd_pin,
  input wire logic reverse_pin,
  input wire logic [15:0] cmd_freq,
  input wire logic [15:0] meas_freq,
  input wire logic [10:0] motor_current,
  output logic [15:0] freq_ref,
  output logic freq_hold,
  output logic dc_brake_on,
  output logic output_block,
  output logic start_dcb_dwell_inhibit,
  output logic brake_release,
  output logic relay1,
  output logic relay2
);
  import mbseq_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] din,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = din[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Register index of an aligned offset
  function automatic logic [3:0] reg_index(input logic [5:0] addr);
    return addr[5:2];
  endfunction

  // Reset value per writable register
  function automatic logic [31:0] reset_value(input int idx);
    case (idx)
      0: return RST_CTRL;
      1, 2: return RST_REL_FREQ;
      3: return RST_REL_CUR;
      4: return RST_REL_HOLD;
      5: return RST_ENG_FREQ;
      6: return RST_ENG_HOLD;
      9: return RST_RELAY_SEL;
      default: return RST_DCB;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] run_sync; // Bit 0 feeds bit 1 only
  logic [1:0] rev_sync;
  // Two stages against metastability on the command pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_sync <= 2'h0;
      rev_sync <= 2'h0;
    end else begin
      run_sync <= {run_sync[0], run_cmd_pin};
      rev_sync <= {rev_sync[0], reverse_pin};
    end
  end
  logic run_s;
  logic rev_s;
  assign run_s = run_sync[1];
  assign rev_s = rev_sync[1];

  // ---------------------------------------------------------------
  // Register file and AXI4-Lite write path
  // ---------------------------------------------------------------
  logic [31:0] cfg [NUM_CFG]; // Writable settings
  logic [31:0] next_cfg [NUM_CFG];
  logic aw_held, next_aw_held; // Address taken, write pending
  logic w_held, next_w_held; // Data taken, write pending
  logic [5:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;

  // Address and data are taken in either order; the write lands once both are held
  always_comb begin
    next_cfg = cfg;
    next_aw_held = aw_held | (s_axi_awvalid & s_axi_awready);
    next_w_held = w_held | (s_axi_wvalid & s_axi_wready);
    next_aw_addr = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : w_strb;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      if (reg_index(aw_addr) < 4'(NUM_CFG) && aw_addr[1:0] == 2'h0) begin
        next_cfg[reg_index(aw_addr)] = merge_bytes(cfg[reg_index(aw_addr)], w_data, w_strb);
        next_bresp = 2'h0;
      end else begin
        // Unmapped or read-only: write dropped
        next_bresp = 2'h2;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg[i] <= reset_value(i);
      end
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      cfg <= next_cfg;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= ~next_aw_held;
      s_axi_wready <= ~next_w_held;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // Named settings
  logic seq_en;
  logic [15:0] rel_fwd, rel_rev, eng_freq;
  logic [10:0] rel_cur;
  logic [9:0] rel_hold, eng_hold, dcb_time;
  logic [10:0] dcb_level;
  logic [7:0] sel_r1, sel_r2;
  assign seq_en = cfg[reg_index(OFS_CTRL)][CTRL_EN_BIT];
  assign rel_fwd = cfg[reg_index(OFS_REL_FWD)][15:0];
  assign rel_rev = cfg[reg_index(OFS_REL_REV)][15:0];
  assign rel_cur = cfg[reg_index(OFS_REL_CUR)][10:0];
  assign rel_hold = cfg[reg_index(OFS_REL_HOLD)][9:0];
  assign eng_freq = cfg[reg_index(OFS_ENG_FREQ)][15:0];
  assign eng_hold = cfg[reg_index(OFS_ENG_HOLD)][9:0];
  assign dcb_time = cfg[reg_index(OFS_DCB_TIME)][9:0];
  assign dcb_level = cfg[reg_index(OFS_DCB_LEVEL)][10:0];
  assign sel_r1 = cfg[reg_index(OFS_RELAY_SEL)][SEL_R1_LSB +: 8];
  assign sel_r2 = cfg[reg_index(OFS_RELAY_SEL)][SEL_R2_LSB +: 8];

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  mbseq_state_t state, next_state;
  logic dir_rev, next_dir_rev; // Direction caught at start
  logic [21:0] pre_cnt, next_pre_cnt; // Cycles within one 0.01 s tick
  logic [9:0] hold_left, next_hold_left; // Ticks left in a hold
  logic next_brake, next_block;

  // Hold counter and state walk; zero hold setting leaves after one cycle
  always_comb begin
    next_state = state;
    next_dir_rev = dir_rev;
    next_brake = brake_release;
    next_block = output_block;
    next_pre_cnt = 22'h0;
    next_hold_left = hold_left;
    if (hold_left != 10'h0) begin
      next_pre_cnt = pre_cnt + 22'h1;
      if (pre_cnt == 22'(TICK_CYCLES - 1)) begin // [R11]
        next_pre_cnt = 22'h0;
        next_hold_left = hold_left - 10'h1;
      end
    end
    case (state)
      S_STOP: begin
        if (run_s && seq_en) begin // [R2]
          next_state = S_TO_REL;
          next_dir_rev = rev_s;
          next_block = 1'b0;
        end else if (run_s) begin
          next_block = 1'b0;
        end
      end
      S_TO_REL: begin
        if (!run_s) begin
          next_state = S_STOP;
        end else if (meas_freq >= (dir_rev ? rel_rev : rel_fwd)) begin
          next_state = S_WAIT_CUR;
        end
      end
      S_WAIT_CUR: begin
        if (!run_s) begin
          next_state = S_STOP;
        end else if (motor_current >= rel_cur) begin // [R3]
          next_state = S_REL_HOLD;
          next_brake = 1'b1; // [R10]
          next_hold_left = rel_hold; // [R4]
        end
      end
      S_REL_HOLD: begin
        if (!run_s) begin
          next_state = S_DECEL;
        end else if (hold_left == 10'h0) begin // [R4]
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (!run_s) begin // [R5]
          next_state = S_DECEL;
        end
      end
      S_DECEL: begin
        if (meas_freq <= eng_freq) begin // [R6]
          next_state = S_ENG_HOLD;
          next_brake = 1'b0;
          next_hold_left = eng_hold;
        end
      end
      S_ENG_HOLD: begin
        if (hold_left == 10'h0) begin // [R7]
          if (dcb_time != 10'h0 && dcb_level != 11'h0) begin // [R8]
            next_state = S_DCB;
            next_hold_left = dcb_time;
          end else begin
            next_state = S_STOP;
            next_block = 1'b1;
          end
        end
      end
      S_DCB: begin
        if (hold_left == 10'h0) begin // [R8]
          next_state = S_STOP;
          next_block = 1'b1;
        end
      end
      default: begin
        next_state = S_STOP;
        next_brake = 1'b0;
      end
    endcase
    // Switching sequencing off mid-run falls back to plain running at cmd_freq in S_STOP, with brake engaged
    if (!seq_en) begin
      next_state = S_STOP;
      next_brake = 1'b0; // [R10]
      next_hold_left = 10'h0;
    end
  end

  // Frequency reference follows the state being entered
  logic [15:0] next_freq_ref;
  logic next_freq_hold;
  always_comb begin
    next_freq_hold = 1'b0;
    case (next_state)
      S_STOP: next_freq_ref = (run_s && !seq_en) ? cmd_freq : 16'h0;
      S_TO_REL: next_freq_ref = next_dir_rev ? rel_rev : rel_fwd; // [R2]
      S_WAIT_CUR, S_REL_HOLD, S_ENG_HOLD: begin
        next_freq_ref = freq_ref; // [R4] [R7]
        next_freq_hold = 1'b1;
      end
      S_RUN: next_freq_ref = cmd_freq;
      S_DECEL: next_freq_ref = eng_freq; // [R5]
      default: next_freq_ref = 16'h0; // [R7]
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_STOP;
      dir_rev <= 1'b0;
      pre_cnt <= 22'h0;
      hold_left <= 10'h0;
      brake_release <= 1'b0; // [R10]
      output_block <= 1'b1;
      freq_ref <= 16'h0;
      freq_hold <= 1'b0;
      dc_brake_on <= 1'b0;
      start_dcb_dwell_inhibit <= 1'b0;
      relay1 <= 1'b0;
      relay2 <= 1'b0;
    end else begin
      state <= next_state;
      dir_rev <= next_dir_rev;
      pre_cnt <= next_pre_cnt;
      hold_left <= next_hold_left;
      brake_release <= next_brake;
      output_block <= next_block;
      freq_ref <= next_freq_ref;
      freq_hold <= next_freq_hold;
      dc_brake_on <= (next_state == S_DCB); // [R8]
      start_dcb_dwell_inhibit <= seq_en; // [R1]
      // Other terminal functions live elsewhere; only the brake code drives here
      relay1 <= (sel_r1 == BRAKE_FUNC_CODE) & next_brake; // [R9]
      relay2 <= (sel_r2 == BRAKE_FUNC_CODE) & next_brake; // [R9]
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  // Single-cycle read answer; arready low while an answer waits
  always_comb begin
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = 2'h0;
      next_rdata = 32'h0;
      if (s_axi_araddr[1:0] != 2'h0) begin
        next_rresp = 2'h2;
      end else if (reg_index(s_axi_araddr) < 4'(NUM_CFG)) begin
        next_rdata = cfg[reg_index(s_axi_araddr)];
      end else if (s_axi_araddr == OFS_STATUS) begin
        next_rdata[ST_STATE_LSB +: 4] = state;
        next_rdata[ST_BRAKE_BIT] = brake_release;
        next_rdata[ST_BLOCK_BIT] = output_block;
        next_rdata[ST_FREQ_LSB +: 16] = meas_freq;
      end else begin
        next_rresp = 2'h2;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence seq_enter_eng;
    (state == S_DECEL) ##1 (state == S_ENG_HOLD);
  endsequence
  // Engage hold running out with sequencing still on
  sequence seq_leave_eng;
    (state == S_ENG_HOLD && hold_left == 10'h0 && seq_en) ##1 (state != S_ENG_HOLD);
  endsequence
  chk_inhibit_follows: assert property (seq_en |=> start_dcb_dwell_inhibit) // [R1]
    else $error("inhibit not raised while sequencing on");
  chk_release_target: assert property (state == S_TO_REL |-> freq_ref == (dir_rev ? rel_rev : rel_fwd)) // [R2]
    else $error("wrong release frequency target");
  chk_release_current: assert property ($rose(brake_release) |-> $past(state) == S_WAIT_CUR
      && $past(motor_current) >= $past(rel_cur)) // [R3]
    else $error("brake released without current");
  chk_release_hold: assert property (state == S_REL_HOLD |-> freq_hold && $stable(freq_ref)) // [R4]
    else $error("frequency moved during release hold");
  chk_stop_decel: assert property (state == S_RUN && !run_s && seq_en |=> state == S_DECEL) // [R5]
    else $error("stop did not start deceleration");
  chk_engage_freq: assert property (seq_enter_eng |-> !brake_release && $past(meas_freq) <= eng_freq) // [R6]
    else $error("engage at wrong frequency");
  chk_engage_zero: assert property (seq_leave_eng |-> freq_ref == 16'h0) // [R7]
    else $error("frequency not zero after engage hold");
  chk_dcb_config: assert property (state == S_DCB |-> dcb_time != 10'h0 && dcb_level != 11'h0 && dc_brake_on) // [R8]
    else $error("DC braking without settings");
  chk_relay_route: assert property ($past(sel_r1) == BRAKE_FUNC_CODE |-> relay1 == brake_release) // [R9]
    else $error("relay 1 does not follow brake");
  chk_brake_window: assert property (brake_release |-> state inside {S_REL_HOLD, S_RUN, S_DECEL}) // [R10]
    else $error("brake released outside window");
  chk_zero_hold: assert property (seq_enter_eng ##0 (eng_hold == 10'h0) |=> state != S_ENG_HOLD) // [R11]
    else $error("zero hold did not end at once");
endmodule
